/* File: mzd_bus_master.sv */
// Partner: system bus master issuing single-cycle I/O reads and writes
`timescale 1ns/100ps
module mzd_bus_master (
  input  wire logic        clk,
  input  wire logic        go,
  input  wire logic        wr,
  input  wire logic [15:0] addr,
  output logic      [15:0] io_addr,
  output logic             io_read,
  output logic             io_write
);
  logic [15:0] last;
  always_ff @(posedge clk) begin
    if (go) last <= addr;
  end
  // Idle bus shows garbage, not the last address
  assign io_addr  = go ? addr : ~last;
  assign io_read  = go & ~wr;
  assign io_write = go & wr;
endmodule : mzd_bus_master

/* File: mzd_chk.sv */
// Checker: decode, status and byte-lane relations at the decoder ports
`timescale 1ns/100ps
module mzd_chk
  import mzd_pkg::*;
#(
  parameter int MODULES = MODULE_COUNT
) (
  input wire logic               clk,
  input wire logic               rst,
  input wire logic [15:0]        io_addr,
  input wire logic               io_read,
  input wire logic               io_write,
  input wire logic               io_ack,
  input wire logic               io_rdata_valid,
  input wire logic               mode_16bit,
  input wire logic [3:0]         upper_address_switch_high,
  input wire logic [3:0]         upper_address_switch_low,
  input wire logic               byte_sel_invert,
  input wire logic               board_half_upper,
  input wire logic [MODULES-1:0] module_present_flag,
  input wire logic               first_ctrl_sel,
  input wire logic [2:0]         module_func_addr,
  input wire logic               module_high_byte
);
  logic       acc;
  logic       hit;
  logic [3:0] grp;
  assign acc = io_read | io_write;
  assign hit = mode_16bit && io_addr[15:8] ==
               {upper_address_switch_high, upper_address_switch_low};
  assign grp = io_addr[7:4];
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  reserved_group_a: assert property (
    acc && hit && grp == GRP_RESERVED |=> !io_ack) else $error("rsvd ack");
  upper_match_a: assert property (
    acc && mode_16bit && !hit |=> !io_ack) else $error("foreign ack");
  first_ctrl_a: assert property (
    acc && hit && grp == GRP_FIRST_CTRL |=> first_ctrl_sel && io_ack)
    else $error("ctrl select missing");
  status_read_a: assert property (
    io_read && hit && grp == GRP_STATUS |=> io_rdata_valid)
    else $error("status read unanswered");
  status_write_a: assert property (
    io_write && !io_read |=> !io_rdata_valid) else $error("write answered");
  func_addr_a: assert property (
    acc && hit && grp < GRP_FIRST_CTRL
    |=> module_func_addr == $past(io_addr[2:0])) else $error("func addr");
  high_byte_a: assert property (
    acc && hit && grp < GRP_FIRST_CTRL
    |=> module_high_byte == $past(io_addr[0] ^ byte_sel_invert))
    else $error("byte lane");
  board_half_a: assert property (
    acc && !mode_16bit && io_addr[7] != board_half_upper |=> !io_ack)
    else $error("other half ack");
  empty_conn_a: assert property (
    acc && !mode_16bit && io_addr[6:5] != 2'h3
    && !module_present_flag[io_addr[6:4]] |=> !io_ack)
    else $error("empty slot ack");
endmodule : mzd_chk

bind mzd_decoder mzd_chk #(.MODULES(MODULES)) mzd_chk_inst (.*);

/* File: mzd_decoder.sv */
// Top: I/O address decoder, status registers and interrupt routing
`timescale 1ns/100ps
module mzd_decoder
  import mzd_pkg::*;
#(
  parameter int MODULES  = MODULE_COUNT,
  parameter int BUS_IRQS = 8
) (
  input  wire logic                    clk,
  input  wire logic                    rst,
  // Bus I/O cycle, sampled as synchronous
  input  wire logic [15:0]             io_addr,
  input  wire logic                    io_read,
  input  wire logic                    io_write,
  output logic      [7:0]              io_rdata,
  output logic                         io_rdata_valid,
  output logic                         io_ack,
  // Configuration straps
  input  wire logic                    mode_16bit,
  input  wire logic [3:0]              upper_address_switch_high,
  input  wire logic [3:0]              upper_address_switch_low,
  input  wire logic                    byte_sel_invert,
  input  wire logic                    board_half_upper,
  input  wire logic [MODULES-1:0]      module_is_16bit,
  // Module connector side
  input  wire logic [MODULES-1:0]      module_present_flag,
  input  wire logic [MODULES-1:0]      module_option_bit_zero,
  input  wire logic [MODULES-1:0]      module_option_bit_one,
  output logic      [MODULES-1:0]      module_cs0,
  output logic      [MODULES-1:0]      module_cs1,
  output logic      [FUNC_ADDR_WIDTH-1:0] module_func_addr,
  output logic                         module_high_byte,
  output logic                         first_ctrl_sel,
  output logic                         second_ctrl_sel,
  // Interrupts
  input  wire logic [2*MODULES-1:0]    module_irq,
  input  wire logic [4*MODULES-1:0]    irq_route_sel,
  input  wire logic [6*MODULES-1:0]    irq_bus_line_sel,
  output logic      [BUS_IRQS-1:0]     bus_irq,
  output logic      [2*MODULES-1:0]    first_ctrl_irq,
  output logic      [2*MODULES-1:0]    second_ctrl_irq
);

  logic                 cycle;
  logic                 board_hit;
  logic [3:0]           group;
  logic                 cs_half;
  logic [2:0]           slot;
  logic                 slot_valid;
  logic                 slot_ok;
  logic [MODULES-1:0]   next_cs0;
  logic [MODULES-1:0]   next_cs1;
  logic                 next_first;
  logic                 next_second;
  logic                 status_hit;
  logic [7:0]           next_rdata;
  logic [7:0]           status_word [MODULES];

  assign cycle = io_read || io_write;

  // Block alignment: 256 ports on switches, or 128 ports by bit 7
  always_comb begin
    if (mode_16bit) begin
      board_hit = io_addr[15:8] == {upper_address_switch_high,
                                    upper_address_switch_low};
    end else begin
      board_hit = io_addr[BOARD_SEL_BIT] == board_half_upper;
    end
  end

  // Group index and which chip select of the pair
  always_comb begin
    if (mode_16bit) begin
      group   = io_addr[7:4];
      cs_half = io_addr[4];
    end else begin
      group   = io_addr[6:3];
      cs_half = io_addr[3];
    end
  end

  assign slot       = group[3:1];
  assign slot_valid = group < GRP_FIRST_CTRL;

  // Empty connectors stay silent in 8-bit mode; wide modules need 16-bit
  always_comb begin
    slot_ok = 1'b0;
    if (slot_valid && int'(slot) < MODULES) begin
      if (mode_16bit) begin
        slot_ok = 1'b1;
      end else begin
        slot_ok = module_present_flag[slot]
                  && !module_is_16bit[slot];
      end
    end
  end

  always_comb begin
    next_cs0    = '0;
    next_cs1    = '0;
    next_first  = 1'b0;
    next_second = 1'b0;
    status_hit  = 1'b0;
    if (cycle && board_hit) begin
      if (slot_ok) begin
        if (cs_half) begin
          next_cs1[slot] = 1'b1;
        end else begin
          next_cs0[slot] = 1'b1;
        end
      end
      case (group)
        GRP_FIRST_CTRL:  next_first  = 1'b1;
        GRP_SECOND_CTRL: next_second = 1'b1;
        GRP_STATUS:      status_hit  = io_read;
        GRP_RESERVED:    next_first  = 1'b0;
        default:         next_first  = 1'b0;
      endcase
    end
  end

  // Status word per connector, low three bits of the address (io_addr[2:0]) pick it
  for (genvar g = 0; g < MODULES; g++) begin : g_status
    always_comb begin
      status_word[g] = STATUS_RESET;
      status_word[g][STAT_PRESENT_BIT] = module_present_flag[g];
      status_word[g][STAT_MODULE_OPTION_BIT_ZERO_BIT]    = module_option_bit_zero[g];
      status_word[g][STAT_MODULE_OPTION_BIT_ONE_BIT]    = module_option_bit_one[g];
    end
  end

  always_comb begin
    next_rdata = STATUS_RESET;
    if (status_hit && int'(io_addr[2:0]) < MODULES) begin
      next_rdata = status_word[io_addr[2:0]];
    end
  end

  // Decoded selects registered once per sampled cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      module_cs0      <= '0;
      module_cs1      <= '0;
      first_ctrl_sel  <= 1'b0;
      second_ctrl_sel <= 1'b0;
    end else begin
      module_cs0      <= next_cs0;
      module_cs1      <= next_cs1;
      first_ctrl_sel  <= next_first;
      second_ctrl_sel <= next_second;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      module_func_addr <= '0;
      module_high_byte <= 1'b0;
    end else if (cycle) begin
      module_func_addr <= io_addr[FUNC_ADDR_WIDTH-1:0];
      // Only meaningful to 16-bit modules in 16-bit mode
      module_high_byte <= mode_16bit &&
                          (io_addr[BYTE_SEL_BIT] ^ byte_sel_invert);
    end
  end

  // Writes to status group are accepted but change nothing
  always_ff @(posedge clk) begin
    if (rst) begin
      io_rdata       <= STATUS_RESET;
      io_rdata_valid <= 1'b0;
      io_ack         <= 1'b0;
    end else begin
      io_rdata       <= next_rdata;
      io_rdata_valid <= status_hit;
      io_ack         <= cycle && board_hit && (slot_ok
                        || (group inside {GRP_FIRST_CTRL, GRP_SECOND_CTRL,
                                          GRP_STATUS}));
    end
  end

  mzd_irq_route #(
    .LINES    (2 * MODULES),
    .BUS_IRQS (BUS_IRQS)
  ) u_irq (
    .clk             (clk),
    .rst             (rst),
    .irq_in          (module_irq),
    .route_sel       (irq_route_sel),
    .bus_line_sel    (irq_bus_line_sel),
    .bus_irq         (bus_irq),
    .first_ctrl_irq  (first_ctrl_irq),
    .second_ctrl_irq (second_ctrl_irq)
  );

endmodule : mzd_decoder

/* File: mzd_irq_route.sv */
// Interrupt routing of module interrupt lines to bus or on-board controllers
`timescale 1ns/100ps
module mzd_irq_route
  import mzd_pkg::*;
#(
  parameter int LINES    = 2 * MODULE_COUNT,
  parameter int BUS_IRQS = 8
) (
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire logic [LINES-1:0]            irq_in,
  input  wire logic [2*LINES-1:0]          route_sel,
  input  wire logic [3*LINES-1:0]          bus_line_sel,
  output logic      [BUS_IRQS-1:0]         bus_irq,
  output logic      [LINES-1:0]            first_ctrl_irq,
  output logic      [LINES-1:0]            second_ctrl_irq
);

  logic [BUS_IRQS-1:0] next_bus_irq;
  logic [LINES-1:0]    next_first;
  logic [LINES-1:0]    next_second;

  always_comb begin
    next_bus_irq = '0;
    for (int i = 0; i < LINES; i++) begin
      if (route_sel[2*i +: 2] == ROUTE_BUS && irq_in[i]) begin
        next_bus_irq[bus_line_sel[3*i +: 3]] = 1'b1;
      end
    end
  end

  for (genvar g = 0; g < LINES; g++) begin : g_line
    assign next_first[g]  = irq_in[g] && route_sel[2*g +: 2] == ROUTE_FIRST;
    assign next_second[g] = irq_in[g] && route_sel[2*g +: 2] == ROUTE_SECOND;
  end

  // Registered so the bus sees glitch-free request levels
  always_ff @(posedge clk) begin
    if (rst) begin
      bus_irq         <= '0;
      first_ctrl_irq  <= '0;
      second_ctrl_irq <= '0;
    end else begin
      bus_irq         <= next_bus_irq;
      first_ctrl_irq  <= next_first;
      second_ctrl_irq <= next_second;
    end
  end

endmodule : mzd_irq_route

/* File: mzd_pkg.sv */
// Package: address map, field positions and widths for the mezzanine decoder
package mzd_pkg;

  localparam int MODULE_COUNT    = 6;
  localparam int GROUP_WIDTH     = 4;
  // Group codes within the low address byte (group index)
  localparam logic [3:0] GRP_FIRST_CTRL  = 4'hC;
  localparam logic [3:0] GRP_SECOND_CTRL = 4'hD;
  localparam logic [3:0] GRP_STATUS      = 4'hE;
  localparam logic [3:0] GRP_RESERVED    = 4'hF;
  // Bit positions
  localparam int BYTE_SEL_BIT    = 0;
  localparam int BOARD_SEL_BIT   = 7;
  localparam int FUNC_ADDR_WIDTH = 3;
  // Status register layout
  localparam int STAT_PRESENT_BIT = 0;
  localparam int STAT_MODULE_OPTION_BIT_ZERO_BIT    = 1;
  localparam int STAT_MODULE_OPTION_BIT_ONE_BIT    = 2;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  // Interrupt routing codes per interrupt line
  localparam logic [1:0] ROUTE_OFF    = 2'h0;
  localparam logic [1:0] ROUTE_BUS    = 2'h1;
  localparam logic [1:0] ROUTE_FIRST  = 2'h2;
  localparam logic [1:0] ROUTE_SECOND = 2'h3;

endpackage : mzd_pkg

/* File: testbench.sv */
// Testbench: decoder address map, status bytes and interrupt routing
`timescale 1ns/100ps
module testbench;
  import mzd_pkg::*;
  logic clk, rst, go, wr, io_read, io_write, io_ack, io_rdata_valid;
  logic mode_16bit, byte_sel_invert, board_half_upper, module_high_byte;
  logic first_ctrl_sel, second_ctrl_sel;
  logic [3:0]  upper_address_switch_high, upper_address_switch_low;
  logic [15:0] io_addr, addr;
  logic [7:0]  io_rdata, bus_irq;
  logic [5:0]  module_is_16bit, module_present_flag, module_cs0, module_cs1;
  logic [5:0]  module_option_bit_zero, module_option_bit_one;
  logic [2:0]  module_func_addr;
  logic [11:0] module_irq, first_ctrl_irq, second_ctrl_irq;
  logic [23:0] irq_route_sel;
  logic [35:0] irq_bus_line_sel;
  int mismatches, total_checks, cyc;
  mzd_bus_master mzd_bus_master_inst (.*);
  mzd_decoder mzd_decoder_inst (.*);
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  task check(input string n, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : check
  task acc(input logic [15:0] a, input logic w);
    logic [3:0] g;
    logic [2:0] m;
    logic       on;
    logic [5:0] c;
    @(posedge clk);
    go <= 1'b1;
    addr <= a;
    wr <= w;
    @(posedge clk);
    go <= 1'b0;
    #1;
    g = mode_16bit ? a[7:4] : a[6:3];
    m = g[3:1];
    on = g != 4'hF && (mode_16bit ? a[15:8] == 8'h5A : a[7] == board_half_upper
         && (g > 11 || module_present_flag[m] && !module_is_16bit[m]));
    c = (on && g < 12) ? 6'(1 << m) : 6'h00;
    check("ack", 32'(on), 32'(io_ack));
    check("cs0", 32'(g[0] ? 6'h00 : c), 32'(module_cs0));
    check("cs1", 32'(g[0] ? c : 6'h00), 32'(module_cs1));
    check("ctrl", {on && g == 12, on && g == 13},
          {first_ctrl_sel, second_ctrl_sel});
    check("rvalid", 32'(on && g == 14 && !w), 32'(io_rdata_valid));
    if (on && g == 14 && !w) check("status", a[2:0] > 5 ? 0 :
      {module_option_bit_one[a[2:0]], module_option_bit_zero[a[2:0]],
       module_present_flag[a[2:0]]}, 32'(io_rdata));
    if (c != 0) check("fn", {mode_16bit & (a[0] ^ byte_sel_invert), a[2:0]},
                      {module_high_byte, module_func_addr});
  endtask : acc
  task close_out;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : close_out
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      close_out();
    end
  end
  initial begin
    {rst, mode_16bit, go, wr, addr, byte_sel_invert} = {3'h6, 18'h0_0000};
    {upper_address_switch_high, upper_address_switch_low} = 8'h5A;
    {board_half_upper, module_is_16bit, module_present_flag} = 13'h0_0495;
    {module_option_bit_zero, module_option_bit_one} = 12'h1A1;
    {module_irq, irq_route_sel, irq_bus_line_sel} = 72'h0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 256; i++) acc({8'h5A, 8'(i)}, i[3]);
    $display("test wide map done");
    @(posedge clk);
    byte_sel_invert <= 1'b1;
    acc(16'h5B21, 1'b0);
    acc(16'h5A21, 1'b0);
    $display("test upper byte and lane done");
    @(posedge clk);
    mode_16bit <= 1'b0;
    for (int i = 0; i < 256; i++) acc({8'hC3, 8'(i)}, i[2]);
    $display("test narrow map done");
    @(posedge clk);
    board_half_upper <= 1'b1;
    acc(16'h00F1, 1'b0);
    acc(16'h0071, 1'b0);
    $display("test upper half done");
    @(posedge clk);
    module_irq <= 12'h00F;
    irq_route_sel <= 24'h00_001E;
    irq_bus_line_sel <= 36'h0_0000_00C0;
    repeat (2) @(posedge clk);
    #1;
    check("irq", {8'h08, 12'h002, 12'h001},
          {bus_irq, second_ctrl_irq, first_ctrl_irq});
    $display("test irq routing done");
    close_out();
  end
endmodule : testbench
